// ==== rtl/snv_top.sv ====
`timescale 1ns/1ps
module snv_top #(
  parameter int ADDR_W     = snv_pkg::ADDR_W,
  parameter int FIFO_DEPTH = snv_pkg::FIFO_DEPTH
) (
  input  wire logic CLK_SYS,
  input  wire logic SYS_RST,
  input  wire logic SPI_CS_N,
  input  wire logic SPI_SCK,
  input  wire logic SPI_SI,
  output logic      SPI_SO,
  output logic      SPI_SO_OE,
  input  wire logic WRITE_PROTECT_N,
  input  wire logic HOLD_N,
  input  wire logic BUSY_SAVE_I,
  output logic      BUSY_SAVE_O,
  output logic      BUSY_SAVE_OE,
  input  wire logic POWER_FAIL,
  output logic      STANDBY,
  output logic      NV_BUSY,
  output logic      FIFO_READY
);
  localparam int DW = snv_pkg::DATA_W;
  localparam int FW = ADDR_W + DW;

  if (ADDR_W < 3 || ADDR_W > 8 * snv_pkg::ADDR_BYTES) begin : g_chk
    $error("address width out of range");
  end

  logic [snv_pkg::PIN_N-1:0] pin_raw;
  logic [snv_pkg::PIN_N-1:0] sync1_r;
  logic [snv_pkg::PIN_N-1:0] sync2_r;
  logic                      sck_prev_r;
  logic                      pf_prev_r;

  assign pin_raw = {SPI_CS_N, SPI_SCK, SPI_SI, HOLD_N, WRITE_PROTECT_N, BUSY_SAVE_I,
                    POWER_FAIL};

  // two-stage synchronisers, one per pin
  for (genvar i = 0; i < snv_pkg::PIN_N; i++) begin : g_sync
    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
        sync1_r[i] <= snv_pkg::PIN_RST[i];
        sync2_r[i] <= snv_pkg::PIN_RST[i];
      end else begin
        sync1_r[i] <= pin_raw[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sck_prev_r <= 1'b0;
      pf_prev_r  <= 1'b0;
    end else begin
      sck_prev_r <= sync2_r[snv_pkg::P_SCK];
      pf_prev_r  <= sync2_r[snv_pkg::P_PF];
    end
  end

  logic cs_n;
  logic si;
  logic active;
  logic sck_rise;
  logic sck_fall;

  assign cs_n     = sync2_r[snv_pkg::P_CS];
  assign si       = sync2_r[snv_pkg::P_SI];
  // hold freezes edge detection; the shifter keeps its place
  assign active   = !cs_n && sync2_r[snv_pkg::P_HOLD];
  assign sck_rise = active && sync2_r[snv_pkg::P_SCK] && !sck_prev_r;
  assign sck_fall = active && !sync2_r[snv_pkg::P_SCK] && sck_prev_r;

  snv_pkg::snv_spi_t spi_r;
  snv_pkg::snv_nv_t  nv_r;
  logic [7:0]        rx_r;
  logic [7:0]        rx_byte;
  logic [2:0]        bit_cnt_r;
  logic [1:0]        abyte_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        tx_r;
  logic [7:0]        next_byte_r;
  logic              fetch_pend_r;
  logic              fetch_ack_r;
  logic              so_r;
  logic              is_read_r;
  logic              wel_r;
  logic [1:0]        bp_r;
  logic              wpen_r;
  logic              as_en_r;
  logic              dirty_r;
  logic              nv_busy;
  logic              byte_done;
  logic              opc_hit;
  logic [7:0]        status;

  assign rx_byte   = {rx_r[6:0], si};
  assign byte_done = sck_rise && bit_cnt_r == 3'h7;
  assign opc_hit   = byte_done && spi_r == snv_pkg::SP_OPC;
  assign nv_busy   = nv_r == snv_pkg::NV_STORE || nv_r == snv_pkg::NV_RECALL;

  always_comb begin
    status                   = 8'h00;
    status[snv_pkg::ST_RDY]  = nv_busy;
    status[snv_pkg::ST_WEL]  = wel_r;
    status[snv_pkg::ST_BP_HI:snv_pkg::ST_BP_LO] = bp_r;
    status[snv_pkg::ST_WPEN] = wpen_r;
  end

  function automatic logic prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      snv_pkg::BP_QTR:  prot = &a[ADDR_W-1 -: 2];
      snv_pkg::BP_HALF: prot = a[ADDR_W-1];
      snv_pkg::BP_ALL:  prot = 1'b1;
      default:          prot = 1'b0;
    endcase
  endfunction : prot

  logic wp_lock;
  logic wr_push;
  logic sr_write;

  // pin asserted with the enable bit set locks the status register; protected blocks are refused by bp_r alone
  assign wp_lock  = wpen_r && !sync2_r[snv_pkg::P_WP];
  assign wr_push  = byte_done && spi_r == snv_pkg::SP_WDATA && wel_r && !nv_busy
                    && !prot(addr_r, bp_r);
  assign sr_write = byte_done && spi_r == snv_pkg::SP_SRIN;

  // serial command engine
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || cs_n) begin
      spi_r     <= snv_pkg::SP_OPC;
      bit_cnt_r <= 3'h0;
      abyte_r   <= 2'h0;
      is_read_r <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        case (spi_r)
          snv_pkg::SP_OPC: begin
            case (rx_byte)
              snv_pkg::OP_RDSR:  spi_r <= snv_pkg::SP_SROUT;
              snv_pkg::OP_WRSR:  spi_r <= (wel_r && !wp_lock) ? snv_pkg::SP_SRIN
                                                              : snv_pkg::SP_SKIP;
              snv_pkg::OP_READ,
              snv_pkg::OP_WRITE: begin
                spi_r     <= nv_busy ? snv_pkg::SP_SKIP : snv_pkg::SP_ADDR;
                is_read_r <= rx_byte == snv_pkg::OP_READ;
              end
              default:           spi_r <= snv_pkg::SP_SKIP;
            endcase
          end
          snv_pkg::SP_ADDR: begin
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == 2'(snv_pkg::ADDR_BYTES - 1)) begin
              spi_r <= is_read_r ? snv_pkg::SP_RDATA : snv_pkg::SP_WDATA;
            end
          end
          snv_pkg::SP_SRIN: spi_r <= snv_pkg::SP_SKIP;
          default:          spi_r <= spi_r;
        endcase
      end
    end
  end

  // receive shifter and address counter
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rx_r   <= 8'h00;
      addr_r <= '0;
    end else begin
      if (sck_rise) begin
        rx_r <= rx_byte;
      end
      if (byte_done && spi_r == snv_pkg::SP_ADDR) begin
        addr_r <= ADDR_W'({addr_r, rx_byte});
      end else if (byte_done && spi_r == snv_pkg::SP_WDATA) begin
        addr_r <= addr_r + 1'b1;
      end else if (sck_fall && spi_r == snv_pkg::SP_RDATA && bit_cnt_r == 3'h0) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // transmit side: new bit on each falling edge
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tx_r      <= 8'h00;
      so_r      <= 1'b0;
      SPI_SO    <= 1'b0;
      SPI_SO_OE <= 1'b0;
    end else begin
      if (sck_fall && bit_cnt_r == 3'h0 &&
          (spi_r == snv_pkg::SP_RDATA || spi_r == snv_pkg::SP_SROUT)) begin
        tx_r <= (spi_r == snv_pkg::SP_RDATA) ? next_byte_r : status;
        so_r <= (spi_r == snv_pkg::SP_RDATA) ? next_byte_r[7] : status[7];
      end else if (sck_fall) begin
        tx_r <= {tx_r[6:0], 1'b0};
        so_r <= tx_r[6];
      end
      SPI_SO    <= so_r;
      SPI_SO_OE <= active && (spi_r == snv_pkg::SP_RDATA || spi_r == snv_pkg::SP_SROUT);
    end
  end

  // status bits steered by instructions
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wel_r   <= 1'b0;
      bp_r    <= 2'h0;
      wpen_r  <= 1'b0;
      as_en_r <= 1'b1;
    end else begin
      if (opc_hit && rx_byte == snv_pkg::OP_WREN) begin
        wel_r <= 1'b1;
      end else if (opc_hit && rx_byte == snv_pkg::OP_WRITE_DISABLE_CMD) begin
        wel_r <= 1'b0;
      end
      if (sr_write) begin
        bp_r   <= rx_byte[snv_pkg::ST_BP_HI:snv_pkg::ST_BP_LO];
        wpen_r <= rx_byte[snv_pkg::ST_WPEN];
      end
      if (opc_hit && rx_byte == snv_pkg::OP_ASEN) begin
        as_en_r <= 1'b1;
      end else if (opc_hit && rx_byte == snv_pkg::OP_ASDIS) begin
        as_en_r <= 1'b0;
      end
    end
  end

  snv_mem_if #(.AW(ADDR_W), .DW(DW)) sram_if ();
  snv_mem_if #(.AW(ADDR_W), .DW(DW)) nv_if ();

  snv_ram #(.AW(ADDR_W), .DW(DW)) u_sram (.clk(CLK_SYS), .port(sram_if.mem));
  snv_ram #(.AW(ADDR_W), .DW(DW)) u_nv   (.clk(CLK_SYS), .port(nv_if.mem));

  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [FW-1:0] fifo_out_data;

  snv_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .in_valid (wr_push),
    .in_ready (fifo_in_ready),
    .in_data  ({addr_r, rx_byte}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data (fifo_out_data)
  );

  logic [ADDR_W-1:0] walk_addr_r;
  logic [ADDR_W-1:0] walk_prev_r;
  logic              walk_vld_r;
  logic              walk_on;
  logic              fetch_grant;

  assign walk_on        = nv_busy;
  // array reads by the shifter beat queued writes; the walk beats both
  assign fetch_grant    = fetch_pend_r && !walk_on;
  assign fifo_out_ready = !walk_on && !fetch_pend_r;

  always_comb begin
    sram_if.addr  = addr_r;
    sram_if.we    = 1'b0;
    sram_if.wdata = fifo_out_data[DW-1:0];
    nv_if.addr    = walk_addr_r;
    nv_if.we      = 1'b0;
    nv_if.wdata   = sram_if.rdata;
    if (nv_r == snv_pkg::NV_STORE) begin
      sram_if.addr = walk_addr_r;
      nv_if.addr   = walk_prev_r;
      nv_if.we     = walk_vld_r;
    end else if (nv_r == snv_pkg::NV_RECALL) begin
      sram_if.addr  = walk_prev_r;
      sram_if.we    = walk_vld_r;
      sram_if.wdata = nv_if.rdata;
    end else if (!fetch_grant && fifo_out_valid) begin
      sram_if.addr = fifo_out_data[FW-1:DW];
      sram_if.we   = 1'b1;
    end
  end

  // read prefetch: next byte waits in a holding register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fetch_pend_r <= 1'b0;
      fetch_ack_r  <= 1'b0;
      next_byte_r  <= 8'h00;
    end else begin
      fetch_ack_r <= fetch_grant;
      if (fetch_ack_r) begin
        next_byte_r <= sram_if.rdata;
      end
      if ((byte_done && spi_r == snv_pkg::SP_ADDR && abyte_r == 2'(snv_pkg::ADDR_BYTES - 1)
           && is_read_r) ||
          (sck_fall && spi_r == snv_pkg::SP_RDATA && bit_cnt_r == 3'h0)) begin
        fetch_pend_r <= 1'b1;
      end else if (fetch_grant) begin
        fetch_pend_r <= 1'b0;
      end
    end
  end

  logic sw_store_r;
  logic sw_recall_r;
  logic pu_recall_r;
  logic hw_req;
  logic pf_req;
  logic walk_last;
  logic [$clog2(snv_pkg::BUSY_REL_CYC + 1)-1:0] rel_cnt_r;

  assign hw_req    = !sync2_r[snv_pkg::P_BSY] && dirty_r;
  assign pf_req    = sync2_r[snv_pkg::P_PF] && !pf_prev_r && as_en_r && dirty_r;
  assign walk_last = walk_vld_r && (&walk_prev_r);

  // pending instruction requests; no set is taken while a walk is clearing them
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sw_store_r  <= 1'b0;
      sw_recall_r <= 1'b0;
      pu_recall_r <= 1'b1;
    end else begin
      if (opc_hit && rx_byte == snv_pkg::OP_STORE && !nv_busy) begin
        sw_store_r <= 1'b1;
      end else if (nv_r == snv_pkg::NV_STORE) begin
        sw_store_r <= 1'b0;
      end
      if (opc_hit && rx_byte == snv_pkg::OP_RECALL && !nv_busy) begin
        sw_recall_r <= 1'b1;
      end else if (nv_r == snv_pkg::NV_RECALL) begin
        sw_recall_r <= 1'b0;
      end
      if (nv_r == snv_pkg::NV_RECALL) begin
        pu_recall_r <= 1'b0;
      end
    end
  end

  // save/restore sequencer; waits for queued writes to land first
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      nv_r        <= snv_pkg::NV_IDLE;
      walk_addr_r <= '0;
      walk_prev_r <= '0;
      walk_vld_r  <= 1'b0;
      rel_cnt_r   <= '0;
    end else begin
      case (nv_r)
        snv_pkg::NV_IDLE: begin
          walk_addr_r <= '0;
          walk_vld_r  <= 1'b0;
          if (!fifo_out_valid && (pu_recall_r || sw_recall_r)) begin
            nv_r <= snv_pkg::NV_RECALL;
          end else if (!fifo_out_valid && (sw_store_r || hw_req || pf_req)) begin
            nv_r <= snv_pkg::NV_STORE;
          end
        end
        snv_pkg::NV_STORE,
        snv_pkg::NV_RECALL: begin
          walk_addr_r <= walk_addr_r + 1'b1;
          walk_prev_r <= walk_addr_r;
          walk_vld_r  <= 1'b1;
          if (walk_last) begin
            rel_cnt_r <= '0;
            nv_r <= (nv_r == snv_pkg::NV_STORE) ? snv_pkg::NV_RELEASE : snv_pkg::NV_IDLE;
          end
        end
        snv_pkg::NV_RELEASE: begin
          rel_cnt_r <= rel_cnt_r + 1'b1;
          if (rel_cnt_r == $bits(rel_cnt_r)'(snv_pkg::BUSY_REL_CYC - 1)) begin
            nv_r <= snv_pkg::NV_IDLE;
          end
        end
        default: nv_r <= snv_pkg::NV_IDLE;
      endcase
    end
  end

  // written-since-last-transfer flag; only writes outside a walk set it, so the clear wins at a walk's end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dirty_r <= 1'b0;
    end else if (sram_if.we && !walk_on) begin
      dirty_r <= 1'b1;
    end else if (walk_last) begin
      dirty_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      BUSY_SAVE_O  <= 1'b0;
      BUSY_SAVE_OE <= 1'b0;
      NV_BUSY      <= 1'b0;
      STANDBY      <= 1'b1;
      FIFO_READY   <= 1'b0;
    end else begin
      BUSY_SAVE_O  <= nv_r == snv_pkg::NV_RELEASE;
      BUSY_SAVE_OE <= nv_r != snv_pkg::NV_IDLE;
      NV_BUSY      <= nv_busy;
      STANDBY      <= cs_n;
      FIFO_READY   <= fifo_in_ready;
    end
  end
endmodule : snv_top

// ==== rtl/snv_pkg.sv ====
package snv_pkg;
  localparam int          ADDR_W       = 17;
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          ADDR_BYTES   = 3;
  localparam int          CLK_MHZ      = 200;
  localparam int          BUSY_REL_NS  = 50;
  localparam int          BUSY_REL_CYC = (BUSY_REL_NS * CLK_MHZ + 999) / 1000;
  // instruction opcodes
  localparam logic [7:0]  OP_WRSR      = 8'h01;
  localparam logic [7:0]  OP_WRITE     = 8'h02;
  localparam logic [7:0]  OP_READ      = 8'h03;
  localparam logic [7:0]  OP_WRITE_DISABLE_CMD      = 8'h04;
  localparam logic [7:0]  OP_RDSR      = 8'h05;
  localparam logic [7:0]  OP_WREN      = 8'h06;
  localparam logic [7:0]  OP_ASDIS     = 8'h19;
  localparam logic [7:0]  OP_STORE     = 8'h3c;
  localparam logic [7:0]  OP_ASEN      = 8'h59;
  localparam logic [7:0]  OP_RECALL    = 8'h60;
  // status byte fields
  localparam int          ST_RDY       = 0;
  localparam int          ST_WEL       = 1;
  localparam int          ST_BP_LO     = 2;
  localparam int          ST_BP_HI     = 3;
  localparam int          ST_WPEN      = 7;
  localparam logic [1:0]  BP_QTR       = 2'h1;
  localparam logic [1:0]  BP_HALF      = 2'h2;
  localparam logic [1:0]  BP_ALL       = 2'h3;
  // synchroniser lanes
  localparam int          PIN_N        = 7;
  localparam int          P_CS         = 6;
  localparam int          P_SCK        = 5;
  localparam int          P_SI         = 4;
  localparam int          P_HOLD       = 3;
  localparam int          P_WP         = 2;
  localparam int          P_BSY        = 1;
  localparam int          P_PF         = 0;
  localparam logic [6:0]  PIN_RST      = 7'h4e;
  typedef enum logic [2:0] {SP_OPC, SP_ADDR, SP_WDATA, SP_RDATA, SP_SROUT, SP_SRIN, SP_SKIP}
    snv_spi_t;
  typedef enum logic [1:0] {NV_IDLE, NV_STORE, NV_RECALL, NV_RELEASE} snv_nv_t;
endpackage : snv_pkg

// ==== rtl/snv_mem_if.sv ====
`timescale 1ns/1ps
interface snv_mem_if #(parameter int AW = 17, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic          we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport mem (input addr, input we, input wdata, output rdata);
  modport ctl (output addr, output we, output wdata, input rdata);
endinterface : snv_mem_if

// ==== rtl/snv_mem.sv ====
`timescale 1ns/1ps
module snv_ram #(
  parameter int AW = 17,
  parameter int DW = 8
) (
  input wire logic clk,
  snv_mem_if.mem   port
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    port.rdata <= mem[port.addr];
  end
endmodule : snv_ram

module snv_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] buf_r [DEPTH];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  assign out_valid = wp_r != rp_r;
  assign in_ready  = (wp_r[PW-1:0] != rp_r[PW-1:0]) || (wp_r[PW] == rp_r[PW]);
  assign out_data  = buf_r[rp_r[PW-1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
    end else if (in_valid && in_ready) begin
      buf_r[wp_r[PW-1:0]] <= in_data;
      wp_r                <= wp_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rp_r <= '0;
    end else if (out_valid && out_ready) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule : snv_fifo

// ==== bench/snv_props.sv ====
`timescale 1ns/1ps
module snv_props #(
  parameter int ADDR_W = snv_pkg::ADDR_W
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCK,
  input wire logic SPI_SI,
  input wire logic SPI_SO,
  input wire logic SPI_SO_OE,
  input wire logic WRITE_PROTECT_N,
  input wire logic HOLD_N,
  input wire logic BUSY_SAVE_I,
  input wire logic BUSY_SAVE_O,
  input wire logic BUSY_SAVE_OE,
  input wire logic POWER_FAIL,
  input wire logic STANDBY,
  input wire logic NV_BUSY,
  input wire logic FIFO_READY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // walk length plus a little slack for the sync stages
  localparam int BUSY_MAX = (1 << ADDR_W) + 4;
  int busy_cnt_r;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !NV_BUSY) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end
  sequence s_drive_low;
    BUSY_SAVE_OE && !BUSY_SAVE_O;
  endsequence
  sequence s_drive_high;
    BUSY_SAVE_OE && BUSY_SAVE_O;
  endsequence
  a_standby_idle: assert property (SPI_CS_N [*5] |-> STANDBY)
    else $error("standby missing while deselected");
  a_standby_active: assert property (!SPI_CS_N [*5] |-> !STANDBY)
    else $error("standby while selected");
  a_so_released: assert property (SPI_CS_N [*8] |-> !SPI_SO_OE)
    else $error("output driven while deselected");
  a_hold_quiet: assert property (!HOLD_N [*8] |-> !SPI_SO_OE)
    else $error("output driven during hold");
  a_so_steady: assert property ((SPI_SCK && !SPI_CS_N && HOLD_N) [*8] |-> $stable(SPI_SO))
    else $error("output moved while clock high");
  a_busy_low: assert property ($rose(NV_BUSY) |-> ##[0:1] s_drive_low [*8])
    else $error("busy pin not driven low");
  a_release_high: assert property (($rose(BUSY_SAVE_O) && BUSY_SAVE_OE) |->
    s_drive_high [*8] ##1 s_drive_high ##1 s_drive_high ##1 !BUSY_SAVE_OE)
    else $error("busy pin release drive wrong");
  a_busy_bounded: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("busy lasts too long");
endmodule : snv_props

bind snv_top snv_props #(.ADDR_W(ADDR_W)) snv_props_inst (.*);

// ==== bench/snv_master.sv ====
`timescale 1ns/1ps
module snv_master (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  // 25 system cycles per link period (125 ns), well inside the maximum rate
  localparam int LO_CYC = 12;
  localparam int HI_CYC = 13;
  logic cpol = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // pins move only on rising edges of clk; tasks end on such an edge
  task automatic frame_start(input logic mode3);
    @(posedge clk);
    cpol = mode3;
    sck <= mode3;
    repeat (LO_CYC) @(posedge clk);
    cs_n <= 1'b0;
    repeat (LO_CYC) @(posedge clk);
  endtask : frame_start
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= tx[i];
      repeat (LO_CYC) @(posedge clk);
      sck <= 1'b1;
      rx[i] = so;
      repeat (HI_CYC) @(posedge clk);
    end
  endtask : xfer
  // clock pulses with no data, for edges that must be ignored
  task automatic wiggle(input int n);
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      repeat (LO_CYC) @(posedge clk);
      sck <= 1'b1;
      repeat (HI_CYC) @(posedge clk);
    end
  endtask : wiggle
  task automatic frame_end();
    if (!cpol) sck <= 1'b0;
    repeat (LO_CYC) @(posedge clk);
    cs_n <= 1'b1;
    // deselected line must not look held
    si <= ~si;
    repeat (4 * LO_CYC) @(posedge clk);
  endtask : frame_end
endmodule : snv_master

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam int AW = 4;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       wp_n = 1'b1;
  logic       hold_n = 1'b1;
  logic       pfail = 1'b0;
  logic       ext_low = 1'b0;
  logic       so_alt = 1'b0;
  logic       cs_n, sck, si, so, so_oe, bs_o, bs_oe, stby, nvb, frdy;
  logic [7:0] mem [16];
  logic [7:0] exp_q [$];
  logic [7:0] obs;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n_starts = 0;
  int         n_low = 0;
  int         n_seen = 0;
  logic       nvb_q = 1'b0;
  event       got;
  wire        so_w = so_oe ? so : so_alt;
  wire        bs_w = (bs_oe ? bs_o : 1'b1) & ~ext_low;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) so_alt <= ~so_alt;
  snv_top #(.ADDR_W(AW)) snv_top_inst (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SI(si),
    .SPI_SO(so), .SPI_SO_OE(so_oe), .WRITE_PROTECT_N(wp_n), .HOLD_N(hold_n),
    .BUSY_SAVE_I(bs_w), .BUSY_SAVE_O(bs_o), .BUSY_SAVE_OE(bs_oe), .POWER_FAIL(pfail),
    .STANDBY(stby), .NV_BUSY(nvb), .FIFO_READY(frdy));
  snv_master snv_master_inst (.clk(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so_w));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  always @(got) check(obs, exp_q.pop_front());
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      conclude();
    end
  end
  // walks are counted as they start: an instruction walk ends inside its own frame
  always @(posedge clk_sys) begin
    nvb_q <= nvb;
    if (nvb === 1'b1 && nvb_q !== 1'b1) begin
      n_starts <= n_starts + 1;
      if (bs_w === 1'b0) n_low <= n_low + 1;
    end
  end
  task automatic take(input logic [7:0] want);
    logic [7:0] r;
    exp_q.push_back(want);
    snv_master_inst.xfer(8'($urandom), r);
    obs = r;
    ->got;
  endtask : take
  task automatic cmd(input logic [7:0] op, input int arg);
    logic [7:0] r;
    snv_master_inst.frame_start(1'b0);
    snv_master_inst.xfer(op, r);
    if (arg >= 0) snv_master_inst.xfer(8'(arg), r);
    snv_master_inst.frame_end();
  endtask : cmd
  task automatic rdsr(input logic [7:0] want);
    logic [7:0] r;
    snv_master_inst.frame_start(1'b1);
    snv_master_inst.xfer(snv_pkg::OP_RDSR, r);
    take(want);
    snv_master_inst.frame_end();
  endtask : rdsr
  task automatic wr(input logic [23:0] a, input int n, input bit ok);
    logic [7:0] r;
    logic [7:0] d;
    snv_master_inst.frame_start(1'b0);
    snv_master_inst.xfer(snv_pkg::OP_WRITE, r);
    for (int i = 16; i >= 0; i -= 8) snv_master_inst.xfer(a[i+:8], r);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      snv_master_inst.xfer(d, r);
      if (ok) mem[AW'(a + 24'(i))] = d;
    end
    snv_master_inst.frame_end();
  endtask : wr
  task automatic rd(input logic [23:0] a, input int n, input logic m3, input logic hold);
    logic [7:0] r;
    snv_master_inst.frame_start(m3);
    snv_master_inst.xfer(snv_pkg::OP_READ, r);
    for (int i = 16; i >= 0; i -= 8) snv_master_inst.xfer(a[i+:8], r);
    if (hold) begin
      @(posedge clk_sys) hold_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      // edges during hold must not advance the transfer
      snv_master_inst.wiggle(3);
      hold_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
    end
    for (int i = 0; i < n; i++) take(mem[AW'(a + 24'(i))]);
    snv_master_inst.frame_end();
  endtask : rd
  task automatic nv_wait(input logic want);
    int k;
    for (k = 0; k < 60 && nvb !== 1'b1; k++) @(posedge clk_sys);
    for (k = 0; k < 200 && nvb !== 1'b0; k++) @(posedge clk_sys);
    repeat (15) @(posedge clk_sys);
    check(8'(n_starts - n_seen), {7'h00, want});
    check(8'(n_low - n_seen), {7'h00, want});
    n_seen = n_starts;
  endtask : nv_wait
  task automatic pin_pull();
    @(posedge clk_sys) ext_low <= 1'b1;
    repeat (5) @(posedge clk_sys);
    ext_low <= 1'b0;
  endtask : pin_pull
  initial begin
    void'($urandom(78));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    nv_wait(1'b1);
    check({7'h00, frdy}, 8'h01);
    cmd(snv_pkg::OP_WREN, -1);
    rdsr(8'h02);
    wr(24'hfffffe, 3, 1'b1);
    rd(24'h00000e, 3, 1'b1, 1'b0);
    rd(24'h7a000e, 3, 1'b0, 1'b1);
    wr(24'h000001, 1, 1'b1);
    cmd(snv_pkg::OP_WRITE_DISABLE_CMD, -1);
    wr(24'h000001, 1, 1'b0);
    rd(24'h000001, 1, 1'b0, 1'b0);
    for (int b = 1; b < 4; b++) begin
      cmd(snv_pkg::OP_WREN, -1);
      cmd(snv_pkg::OP_WRSR, b << 2);
      wr(24'h00000f, 1, 1'b0);
      wr(24'h000000, 1, b != 3);
      rd(24'h00000f, 2, 1'b0, 1'b0);
    end
    cmd(snv_pkg::OP_WRSR, 'h80);
    @(posedge clk_sys) wp_n <= 1'b0;
    cmd(snv_pkg::OP_WRSR, 'h0c);
    rdsr(8'h82);
    @(posedge clk_sys) wp_n <= 1'b1;
    cmd(snv_pkg::OP_WRSR, 0);
    wr(24'h000003, 1, 1'b1);
    cmd(snv_pkg::OP_STORE, -1);
    nv_wait(1'b1);
    wr(24'h000003, 1, 1'b0);
    cmd(snv_pkg::OP_RECALL, -1);
    nv_wait(1'b1);
    rd(24'h000003, 1, 1'b1, 1'b0);
    pin_pull();
    nv_wait(1'b0);
    wr(24'h000004, 1, 1'b1);
    pin_pull();
    nv_wait(1'b1);
    wr(24'h000005, 1, 1'b1);
    @(posedge clk_sys) pfail <= 1'b1;
    nv_wait(1'b1);
    @(posedge clk_sys) pfail <= 1'b0;
    rd(24'h000004, 2, 1'b0, 1'b0);
    conclude();
  end
endmodule : tb
